//--- sscp_top.v
// serial control port and register logic of a dual loop synthesizer
// assumes serial pins and analog status inputs arrive asynchronous to mclk;
// the serial clock is far slower than mclk so that mclk sees its edges
`include "sscp_defs.vh"
`default_nettype none

module sscp_top
(
  input  wire        mclk,            // system clock
  input  wire        rstn,            // async reset, active low
  input  wire        port_select_n,   // serial select pin
  input  wire        serial_clk,      // serial clock pin
  input  wire        serial_data_in,  // serial data pin
  input  wire        main_lock_raw,   // main loop detector lock
  input  wire        sec_lock_raw,    // secondary loop detector lock
  input  wire        main_ref_tick,   // main reference counter out
  input  wire        sec_ref_tick,    // secondary reference counter out
  input  wire        pd_pulse,        // phase detector pulse indicator
  input  wire        mode_pin,        // mode strap pin
  input  wire        fout_ref,        // divided reference from aux counter
  input  wire        dp_main_i,       // dual pin (fout_n / main pol) in
  output reg         dp_main_o,       // dual pin out
  output reg         dp_main_oe,      // dual pin drive enable
  input  wire        dp_sec_i,        // dual pin (fout / sec pol) in
  output reg         dp_sec_o,        // dual pin out
  output reg         dp_sec_oe,       // dual pin drive enable
  output reg         main_pd_pol,     // main detector polarity, 1 positive
  output reg         sec_pd_pol,      // secondary detector polarity
  output reg         xref_mode,       // external reference oscillator mode
  output reg         sec_ref_fine,    // secondary ref in 0.5 steps
  output reg         lock_indicator,  // combined lock output
  output reg         lock_window_select, // main lock window select
  output reg  [3:0]  sec_win_ratio,   // secondary lock window ratio
  output reg  [7:0]  dac_out_first,   // first dac code
  output reg  [7:0]  dac_out_second,  // second dac code
  output reg         dac_first_lp,    // first dac low power
  output reg         dac_second_lp,   // second dac low power
  output reg         outa_o,          // output a level
  output reg         outb_o,          // output b level
  output reg         outb_oe,         // output b drive enable
  output wire        outc_o,          // output c level (always low)
  output reg         outc_oe,         // output c pull-down enable
  output reg         main_standby,    // main pll standby
  output reg         sec_standby,     // secondary pll standby
  output reg  [7:0]  control_o,       // control register contents
  output reg  [23:0] main_div_o,      // main divider ratio
  output reg  [15:0] main_ref_div_o,  // main reference divider ratio
  output reg  [15:0] sec_div_o,       // secondary divider ratio
  output reg  [23:0] sec_ref_o,       // secondary reference register
  output reg         ratio_load       // one pulse: new ratios applied
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam NSYNC = 12;
  // select stages reset to its idle high level, so no false edge follows reset
  localparam [NSYNC-1:0] SYNC_RST = `SSCP_SYNC_RST;
  wire [NSYNC-1:0] async_in;        // raw pins gathered
  reg  [NSYNC-1:0] sync1_q;         // first stage, read by stage two only
  reg  [NSYNC-1:0] sync2_q;         // safe copies
  assign async_in = {dp_sec_i, dp_main_i, fout_ref, mode_pin, pd_pulse,
                     sec_ref_tick, main_ref_tick, sec_lock_raw,
                     main_lock_raw, serial_data_in, serial_clk,
                     port_select_n};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1)
    begin : g_sync
      // two flops per pin, only stage two looks at stage one
      always @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
        begin
          sync1_q[gi] <= SYNC_RST[gi];
          sync2_q[gi] <= SYNC_RST[gi];
        end
        else
        begin
          sync1_q[gi] <= async_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate
  wire sel_n_s  = sync2_q[0];       // select, active low
  wire sclk_s   = sync2_q[1];
  wire sdi_s    = sync2_q[2];
  wire mlock_s  = sync2_q[3];
  wire slock_s  = sync2_q[4];
  wire mtick_s  = sync2_q[5];
  wire stick_s  = sync2_q[6];
  wire pdp_s    = sync2_q[7];
  wire mode_s   = sync2_q[8];
  wire fref_s   = sync2_q[9];
  wire dpm_s    = sync2_q[10];
  wire dps_s    = sync2_q[11];
  // output c is open drain: only ever pulls low
  assign outc_o = 1'b0;

  // ----------------------------------------------------------------
  // serial edge detection and shifter
  // ----------------------------------------------------------------
  reg         sclk_d_q;             // previous serial clock
  reg         sel_d_q;              // previous select
  reg  [31:0] shift_q;              // input shift register
  reg  [5:0]  cnt_q;                // clocks seen, saturates
  reg         desync_q;             // port out of step with master
  wire sclk_rise = sclk_s & ~sclk_d_q;
  wire sel_rise  = sel_n_s & ~sel_d_q;
  wire sel_move  = sel_n_s ^ sel_d_q;
  // a select move with clock high spoils the burst; idle low clock
  // with select high brings the port back
  wire desync_set = sel_move & sclk_s;
  wire resync     = sel_n_s & ~sclk_s;
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sclk_d_q <= 1'b0;
      sel_d_q  <= 1'b1;
      desync_q <= 1'b0;
    end
    else
    begin
      sclk_d_q <= sclk_s;
      sel_d_q  <= sel_n_s;
      if (desync_set)
        desync_q <= 1'b1;
      else if (resync)
        desync_q <= 1'b0;
    end
  end
  // shifting only while selected and in step; msb enters first
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      shift_q <= 32'h0000_0000;
      cnt_q   <= 6'h00;
    end
    else if (sel_rise)
    begin
      cnt_q <= 6'h00;
    end
    else if (!sel_n_s && !desync_q && !desync_set && sclk_rise)
    begin
      shift_q <= {shift_q[30:0], sdi_s};
      if (cnt_q != `SSCP_LEN_MAX)
        cnt_q <= cnt_q + 6'h01;
    end
    else if (sel_n_s)
    begin
      cnt_q <= 6'h00;
    end
  end
  // ----------------------------------------------------------------
  // target decode
  // ----------------------------------------------------------------
  // short streams reach only control, ref hold and main divider
  function [3:0] sscp_target;
    input [5:0] len;
    input [3:0] nib;
    begin
      case (len)
        `SSCP_LEN_CTRL: sscp_target = `SSCP_ADR_CTRL;
        `SSCP_LEN_REFH: sscp_target = `SSCP_ADR_REFH;
        `SSCP_LEN_MDIV: sscp_target = `SSCP_ADR_MDIV;
        `SSCP_LEN_ADDR:
          if (nib <= `SSCP_ADR_SREF)
            sscp_target = nib;
          else
            sscp_target = `SSCP_ADR_NONE;
        default: sscp_target = `SSCP_ADR_NONE;
      endcase
    end
  endfunction
  // commit only on a clean select rise with the clock low
  wire       commit = sel_rise & ~sclk_s & ~desync_q;
  wire [3:0] target = sscp_target(cnt_q,
                        shift_q[`SSCP_ADR_HI:`SSCP_ADR_LO]);
  // ----------------------------------------------------------------
  // programmable registers
  // ----------------------------------------------------------------
  reg [7:0]  control_q;             // control bits
  reg [15:0] ref_hold_q;            // main ref divider holding
  reg [23:0] main_div_q;            // main divider
  reg [15:0] dac_q;                 // dac codes
  reg [15:0] sec_div_hold_q;        // secondary divider holding
  reg [23:0] sec_ref_q;             // secondary reference
  reg [15:0] main_ref_div_q;        // active main ref ratio
  reg [15:0] sec_div_q;             // active secondary ratio
  reg        load_q;                // ratios just applied

  // payload is right justified, so the low bits always carry it
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      control_q      <= `SSCP_CTRL_RST;
      ref_hold_q     <= `SSCP_ZERO16;
      main_div_q     <= `SSCP_ZERO24;
      dac_q          <= `SSCP_ZERO16;
      sec_div_hold_q <= `SSCP_ZERO16;
      sec_ref_q      <= `SSCP_ZERO24;
      main_ref_div_q <= `SSCP_ZERO16;
      sec_div_q      <= `SSCP_ZERO16;
      load_q         <= 1'b0;
    end
    else
    begin
      load_q <= 1'b0;
      if (commit)
      begin
        case (target)
          `SSCP_ADR_CTRL:  control_q      <= shift_q[7:0];
          `SSCP_ADR_REFH:  ref_hold_q     <= shift_q[15:0];
          `SSCP_ADR_MDIV:
          begin
            main_div_q     <= shift_q[23:0];
            main_ref_div_q <= ref_hold_q;
            sec_div_q      <= sec_div_hold_q;
            load_q         <= 1'b1;
          end
          `SSCP_ADR_DAC:   dac_q          <= shift_q[15:0];
          `SSCP_ADR_SDIVH: sec_div_hold_q <= shift_q[15:0];
          `SSCP_ADR_SREF:  sec_ref_q      <= shift_q[23:0];
          default:         load_q         <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // lock, dac and general outputs
  // ----------------------------------------------------------------
  wire       m_sby = control_q[`SSCP_C_MAIN_SBY];
  wire       s_sby = control_q[`SSCP_C_SEC_SBY];
  wire [1:0] a_sel = {sec_ref_q[`SSCP_SR_OUTA_HI],
                      sec_ref_q[`SSCP_SR_OUTA_LO]};

  // all outputs but the constant outc_o registered; lock reads low until detected
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      lock_indicator     <= 1'b0;
      lock_window_select <= 1'b0;
      sec_win_ratio      <= `SSCP_SEC_WIN_RATIO;
      dac_out_first      <= `SSCP_ZERO8;
      dac_out_second     <= `SSCP_ZERO8;
      dac_first_lp       <= 1'b1;
      dac_second_lp      <= 1'b1;
      outa_o             <= 1'b0;
      outb_o             <= 1'b0;
      outb_oe            <= 1'b0;
      outc_oe            <= 1'b1;
      main_standby       <= 1'b1;
      sec_standby        <= 1'b0;
      control_o          <= `SSCP_CTRL_RST;
      main_div_o         <= `SSCP_ZERO24;
      main_ref_div_o     <= `SSCP_ZERO16;
      sec_div_o          <= `SSCP_ZERO16;
      sec_ref_o          <= `SSCP_ZERO24;
      ratio_load         <= 1'b0;
      main_pd_pol        <= 1'b1;
      sec_pd_pol         <= 1'b1;
      dp_main_o          <= 1'b0;
      dp_main_oe         <= 1'b0;
      dp_sec_o           <= 1'b0;
      dp_sec_oe          <= 1'b0;
      xref_mode          <= 1'b0;
      sec_ref_fine       <= 1'b0;
    end
    else
    begin
      // standby loops drop out of the and
      if (m_sby && s_sby)
        lock_indicator <= 1'b0;
      else if (m_sby)
        lock_indicator <= slock_s;
      else if (s_sby)
        lock_indicator <= mlock_s;
      else
        lock_indicator <= mlock_s & slock_s;
      lock_window_select <= main_div_q[`SSCP_N_WIN_SEL];
      sec_win_ratio      <= `SSCP_SEC_WIN_RATIO;
      dac_out_first      <= dac_q[7:0];
      dac_out_second     <= dac_q[15:8];
      dac_first_lp       <= (dac_q[7:0] == `SSCP_ZERO8);
      dac_second_lp      <= (dac_q[15:8] == `SSCP_ZERO8);
      // event sources rest low and pulse high as they arrive
      case (a_sel)
        `SSCP_OUTA_STATIC: outa_o <= control_q[`SSCP_C_OUTA_LVL];
        `SSCP_OUTA_MTICK:  outa_o <= mtick_s;
        `SSCP_OUTA_STICK:  outa_o <= stick_s;
        default:           outa_o <= pdp_s;
      endcase
      // output b: level while active, floats in main standby or mode high
      outb_o  <= control_q[`SSCP_C_OUTB_LVL];
      outb_oe <= ~m_sby & ~mode_s;
      outc_oe <= ~control_q[`SSCP_C_OUTC_LVL];
      main_standby   <= m_sby;
      sec_standby    <= s_sby;
      control_o      <= control_q;
      main_div_o     <= main_div_q;
      main_ref_div_o <= main_ref_div_q;
      sec_div_o      <= sec_div_q;
      sec_ref_o      <= sec_ref_q;
      ratio_load     <= load_q;
      xref_mode      <= mode_s & control_q[`SSCP_C_OUTB_LVL];
      sec_ref_fine   <= mode_s;
      // dual purpose pins: differential ref out, or polarity in
      if (mode_s)
      begin
        dp_main_oe  <= 1'b0;
        dp_sec_oe   <= 1'b0;
        main_pd_pol <= dpm_s;
        sec_pd_pol  <= dps_s;
        dp_main_o   <= 1'b0;
        dp_sec_o    <= 1'b0;
      end
      else
      begin
        dp_main_oe  <= 1'b1;
        dp_sec_oe   <= 1'b1;
        dp_sec_o    <= fref_s;
        dp_main_o   <= ~fref_s;
        main_pd_pol <= 1'b1;
        sec_pd_pol  <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

//--- sscp_defs.vh
// constants for the synthesizer serial control port block
// assumes inclusion by sscp_top.v only; definitions only, no logic
`ifndef SSCP_DEFS_VH
`define SSCP_DEFS_VH

// ----------------------------------------------------------------
// register selectors (address nibble values)
// ----------------------------------------------------------------
`define SSCP_ADR_CTRL      4'h0
`define SSCP_ADR_REFH      4'h1
`define SSCP_ADR_MDIV      4'h2
`define SSCP_ADR_DAC       4'h3
`define SSCP_ADR_SDIVH     4'h4
`define SSCP_ADR_SREF      4'h5
`define SSCP_ADR_NONE      4'hf

// ----------------------------------------------------------------
// stream lengths in serial clocks
// ----------------------------------------------------------------
`define SSCP_LEN_CTRL      6'h08
`define SSCP_LEN_REFH      6'h10
`define SSCP_LEN_MDIV      6'h18
`define SSCP_LEN_ADDR      6'h20
`define SSCP_LEN_MAX       6'h21

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SSCP_ADR_HI        31
`define SSCP_ADR_LO        28
`define SSCP_C_OUTA_LVL    7
`define SSCP_C_OUTB_LVL    6
`define SSCP_C_OUTC_LVL    5
`define SSCP_C_SEC_SBY     2
`define SSCP_C_MAIN_SBY    1
`define SSCP_N_WIN_SEL     22
`define SSCP_SR_OUTA_HI    21
`define SSCP_SR_OUTA_LO    20

// ----------------------------------------------------------------
// reset values and fixed ratios
// ----------------------------------------------------------------
`define SSCP_CTRL_RST      8'h02
`define SSCP_ZERO8         8'h00
`define SSCP_ZERO16        16'h0000
`define SSCP_ZERO24        24'h00_0000
`define SSCP_SYNC_RST      12'h001
`define SSCP_SEC_WIN_RATIO 4'h8

// ----------------------------------------------------------------
// output a source selects
// ----------------------------------------------------------------
`define SSCP_OUTA_STATIC   2'h0
`define SSCP_OUTA_MTICK    2'h1
`define SSCP_OUTA_STICK    2'h2
`define SSCP_OUTA_PDPULSE  2'h3

`endif

//--- sscp_asserts.sv
// concurrent checks on the outputs of the serial control port
// assumes binding into sscp_top; sees only that module's ports
`default_nettype none
module sscp_asserts
(
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        main_lock_raw,
  input wire logic        sec_lock_raw,
  input wire logic        main_ref_tick,
  input wire logic        lock_indicator,
  input wire logic [7:0]  dac_out_first,
  input wire logic [7:0]  dac_out_second,
  input wire logic        dac_first_lp,
  input wire logic        dac_second_lp,
  input wire logic        outa_o,
  input wire logic        outb_o,
  input wire logic        outb_oe,
  input wire logic        outc_o,
  input wire logic        outc_oe,
  input wire logic        main_standby,
  input wire logic        sec_standby,
  input wire logic [7:0]  control_o,
  input wire logic [15:0] main_ref_div_o,
  input wire logic [15:0] sec_div_o,
  input wire logic [23:0] sec_ref_o,
  input wire logic        ratio_load
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // checks, one clock domain
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // five cycles cover the three-flop path from the lock pins
  lock_and_a: assert property (
    (!main_lock_raw && !main_standby) [*5] |-> !lock_indicator)
    else $error("lock high while active main loop unlocked");
  lock_both_a: assert property (
    (main_lock_raw && sec_lock_raw && !main_standby && !sec_standby) [*5] |-> lock_indicator)
    else $error("lock low with both loops locked");
  sby_low_a: assert property (
    main_standby && sec_standby |-> !lock_indicator)
    else $error("lock high with both loops in standby");
  sby_sec_a: assert property (
    (main_standby && !sec_standby && sec_lock_raw) [*5] |-> lock_indicator)
    else $error("lock ignores the only active loop");
  outc_drive_a: assert property (
    outc_oe == !control_o[5] && !outc_o)
    else $error("output c drive wrong for its level bit");
  outb_state_a: assert property (
    outb_oe |-> !control_o[1] && outb_o == control_o[6])
    else $error("output b driven in standby or at wrong level");
  dac_lp_a: assert property (
    dac_first_lp == (dac_out_first == 8'h00) && dac_second_lp == (dac_out_second == 8'h00))
    else $error("dac low power flag does not match zero code");
  ratio_pulse_a: assert property (
    ratio_load |=> !ratio_load)
    else $error("ratio load longer than one cycle");
  ratio_cause_a: assert property (
    $changed(main_ref_div_o) || $changed(sec_div_o) |-> ratio_load)
    else $error("held ratios moved without a divider write");
  outa_static_a: assert property (
    sec_ref_o[21:20] == 2'h0 |-> outa_o == control_o[7])
    else $error("output a static level wrong");
  outa_rest_a: assert property (
    (sec_ref_o[21:20] == 2'h1 && !main_ref_tick) [*5] |-> !outa_o)
    else $error("output a not resting low between ticks");
endmodule
bind sscp_top sscp_asserts u_chk (.mclk, .rstn, .main_lock_raw, .sec_lock_raw, .main_ref_tick,
  .lock_indicator, .dac_out_first, .dac_out_second, .dac_first_lp, .dac_second_lp, .outa_o,
  .outb_o, .outb_oe, .outc_o, .outc_oe, .main_standby, .sec_standby, .control_o,
  .main_ref_div_o, .sec_div_o, .sec_ref_o, .ratio_load);
`default_nettype wire

//--- sscp_mcu_model.sv
// controller model driving select, serial clock and data
// assumes mclk at 8 ns; serial half period of 4 mclk gives 32 ns
`default_nettype none
module sscp_mcu_model
(
  input  wire logic mclk,            // pacing only
  output var  logic port_select_n,   // idle high
  output var  logic serial_clk,      // still low between frames
  output var  logic serial_data_in   // msb first
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    port_select_n  = 1'h1;
    serial_clk     = 1'h0;
    serial_data_in = 1'h0;
  end
  // one half period of the serial clock
  task automatic half();
    repeat (4) @(posedge mclk);
  endtask
  // shift n bits; bad lifts select with the clock high
  task automatic send(input logic [39:0] w, input int n, input logic bad);
    int i;
    half();
    port_select_n <= 1'h0;
    for (i = n - 1; i >= 0; i--)
    begin
      half();
      serial_clk     <= 1'h0;
      serial_data_in <= w[i];
      half();
      serial_clk     <= 1'h1;
    end
    half();
    if (bad)
      port_select_n <= 1'h1;               // deliberate desync
    else
      serial_clk <= 1'h0;
    half();
    port_select_n  <= 1'h1;
    serial_clk     <= 1'h0;
    serial_data_in <= ~serial_data_in;     // released line shows no stale bit
    half();
  endtask
endmodule
`default_nettype wire

//--- sscp_top_tb.sv
// self-checking bench for the serial control port
// assumes sscp_top, the controller model and the checker compiled first
`default_nettype none
module sscp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'h0, rstn = 1'h0;                      // clock and reset
  logic main_lock_raw = 1'h0, sec_lock_raw = 1'h0;     // loop lock flags
  logic main_ref_tick = 1'h0, sec_ref_tick = 1'h0, pd_pulse = 1'h0;
  logic mode_pin = 1'h0, fout_ref = 1'h0;              // strap and divided ref
  logic pol_main = 1'h0, pol_sec = 1'h0;               // board levels on dual pins
  logic port_select_n, serial_clk, serial_data_in;     // from the model
  logic dp_main_o, dp_main_oe, dp_sec_o, dp_sec_oe, main_pd_pol, sec_pd_pol;
  logic xref_mode, sec_ref_fine, lock_indicator, lock_window_select, ratio_load;
  logic dac_first_lp, dac_second_lp, outa_o, outb_o, outb_oe, outc_o, outc_oe;
  logic main_standby, sec_standby;
  logic [3:0]  sec_win_ratio;
  logic [7:0]  dac_out_first, dac_out_second, control_o;
  logic [15:0] main_ref_div_o, sec_div_o;
  logic [23:0] main_div_o, sec_ref_o;
  int          err_total = 0, check_count = 0;
  // dual pin wire: the device wins while it drives
  wire dp_main_i = dp_main_oe ? dp_main_o : pol_main;
  wire dp_sec_i  = dp_sec_oe ? dp_sec_o : pol_sec;
  always #4 mclk = ~mclk;
  sscp_mcu_model mcu (.mclk, .port_select_n, .serial_clk, .serial_data_in);
  sscp_top dut (.mclk, .rstn, .port_select_n, .serial_clk, .serial_data_in, .main_lock_raw,
    .sec_lock_raw, .main_ref_tick, .sec_ref_tick, .pd_pulse, .mode_pin, .fout_ref, .dp_main_i,
    .dp_main_o, .dp_main_oe, .dp_sec_i, .dp_sec_o, .dp_sec_oe, .main_pd_pol, .sec_pd_pol,
    .xref_mode, .sec_ref_fine, .lock_indicator, .lock_window_select, .sec_win_ratio,
    .dac_out_first, .dac_out_second, .dac_first_lp, .dac_second_lp, .outa_o, .outb_o, .outb_oe,
    .outc_o, .outc_oe, .main_standby, .sec_standby, .control_o, .main_div_o, .main_ref_div_o,
    .sec_div_o, .sec_ref_o, .ratio_load);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // sync, commit and output stages, then step off the edge
  task automatic settle();
    repeat (6) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [39:0] w, input int n);
    mcu.send(w, n, 1'h0);
    settle();
  endtask
  task automatic print_verdict();
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_short();
    chk({control_o, outb_oe, outc_oe, lock_indicator}, 11'h012);
    chk({dac_first_lp, dac_second_lp}, 2'h3);
    chk(sec_win_ratio, 4'h8);
    wr(40'h00_0000_00a5, 8);
    chk({control_o, outc_oe, main_standby, sec_standby, outb_oe}, 12'ha53);
    wr(40'h00_0000_1234, 16);
    chk(main_ref_div_o, 16'h0000);
    wr(40'h00_0040_5678, 24);
    chk({main_div_o, main_ref_div_o, lock_window_select}, 41'h80_ACF0_2469);
  endtask
  task automatic t_addr();
    wr(40'h00_3000_8100, 32);
    chk({dac_out_second, dac_out_first, dac_first_lp, dac_second_lp}, 18'h2_0402);
    wr(40'h00_4000_2468, 32);
    wr(40'h00_1000_0055, 32);
    wr(40'h00_5a12_3456, 32);
    chk({sec_ref_o, sec_div_o}, 40'h12_3456_0000);
    wr(40'h00_2000_0123, 32);
    chk({main_div_o, main_ref_div_o, sec_div_o}, 56'h00_0123_0055_2468);
    wr(40'h00_0000_0000, 32);
    chk(control_o, 8'h00);
  endtask
  task automatic t_refuse();
    wr(40'h00_0000_0fff, 12);
    wr(40'hff_ffff_ffff, 40);
    wr(40'h00_60ff_ffff, 32);
    wr(40'h00_000f_ffff, 20);
    wr(40'h00_0000_3fff, 16);
    mcu.send(40'h00_0000_00ff, 8, 1'h1);
    settle();
    chk({control_o, main_div_o, sec_ref_o}, 56'h00_0001_2312_3456);
    chk({dac_out_second, dac_out_first}, 16'h8100);
  endtask
  task automatic t_lock();
    int i;
    for (i = 0; i < 4; i++)
    begin
      @(posedge mclk);
      main_lock_raw <= i[1];
      sec_lock_raw  <= i[0];
      settle();
      chk(lock_indicator, i[1] & i[0]);
    end
    @(posedge mclk) main_lock_raw <= 1'h0;
    wr(40'h00_0000_0002, 8);
    chk(lock_indicator, 1'h1);
    @(posedge mclk);
    main_lock_raw <= 1'h1;
    sec_lock_raw  <= 1'h0;
    wr(40'h00_0000_0004, 8);
    chk(lock_indicator, 1'h1);
    @(posedge mclk) sec_lock_raw <= 1'h1;
    wr(40'h00_0000_0006, 8);
    chk(lock_indicator, 1'h0);
  endtask
  // the selected source driven opposite to the other two, so a wrong pick shows
  task automatic t_outa();
    int s, v;
    wr(40'h00_0000_0080, 8);
    for (s = 0; s < 4; s++)
    begin
      wr({12'h005, 6'h00, s[1:0], 20'h0_0000}, 32);
      for (v = 0; v < 2; v++)
      begin
        @(posedge mclk);
        main_ref_tick <= (s == 1) ? v[0] : !v[0];
        sec_ref_tick  <= (s == 2) ? v[0] : !v[0];
        pd_pulse      <= (s == 3) ? v[0] : !v[0];
        settle();
        chk(outa_o, (s == 0) ? 1'h1 : v[0]);
      end
    end
  endtask
  task automatic t_mode();
    @(posedge mclk) fout_ref <= 1'h1;
    wr(40'h00_0000_0040, 8);
    chk({dp_sec_o, dp_main_o, dp_sec_oe, dp_main_oe, sec_pd_pol, main_pd_pol, sec_ref_fine},
      7'h5e);
    chk({outb_o, outb_oe, xref_mode}, 3'h6);
    @(posedge mclk);
    mode_pin <= 1'h1;
    pol_sec  <= 1'h1;
    wr(40'h00_0000_0040, 8);
    chk({dp_sec_oe, dp_main_oe, sec_pd_pol, main_pd_pol, xref_mode, sec_ref_fine, outb_oe},
      7'h16);
  endtask
  // ------------------------------------------------------------
  // main sequence and hang guard
  // ------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge mclk);
    rstn <= 1'h1;
    settle();
    t_short();
    t_addr();
    t_refuse();
    t_lock();
    t_outa();
    t_mode();
    print_verdict();
  end
  initial
  begin
    repeat (60000) @(posedge mclk);
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
